// >>> adc_mode_pkg.sv
// Constants for the converter mode and calibration control block
package adc_mode_pkg;
    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [3:0] OFS_MODE = 4'h0;
    localparam logic [3:0] OFS_PRI_CTRL = 4'h1;
    localparam logic [3:0] OFS_SEC_CTRL = 4'h2;
    localparam logic [3:0] OFS_STATUS = 4'h3;
    localparam logic [3:0] OFS_PRI_OFFSET = 4'h4;
    localparam logic [3:0] OFS_PRI_GAIN = 4'h5;
    localparam logic [3:0] OFS_SEC_OFFSET = 4'h6;
    localparam logic [3:0] OFS_SEC_GAIN = 4'h7;
    localparam logic [3:0] OFS_PRI_DATA = 4'h8;
    localparam logic [3:0] OFS_SEC_DATA = 4'h9;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int MODE_LSB = 0;
    localparam int MODE_SEL_BIT = 3;
    localparam int MODE_KEEP_BIT = 4;
    localparam int ENABLE_BIT = 0;
    localparam int RATE_LSB = 1;
    localparam int ST_RDY0 = 0;
    localparam int ST_RDY1 = 1;
    localparam int ST_PRIMARY_ERROR_FLAG = 2;
    localparam int ST_NOREF = 3;

    // ************************************************************
    // Mode codes and reset values
    // ************************************************************
    localparam logic [2:0] MD_POWER_DOWN = 3'h0;
    localparam logic [2:0] MD_IDLE = 3'h1;
    localparam logic [2:0] MD_CONTINUOUS = 3'h2;
    localparam logic [2:0] MD_SINGLE = 3'h3;
    localparam logic [2:0] MD_INT_ZERO = 3'h4;
    localparam logic [2:0] MD_INT_FULL = 3'h5;
    localparam logic [2:0] MD_SYS_ZERO = 3'h6;
    localparam logic [2:0] MD_SYS_FULL = 3'h7;
    localparam logic [4:0] MODE_RESET = 5'h00;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam logic [3:0] RATE_SLOWEST = 4'hf;
    localparam logic [23:0] OFFSET_RESET = 24'h800000;
    localparam logic [23:0] GAIN_UNITY = 24'h400000;
    localparam int GAIN_SHIFT = 22;
    localparam int CONV_BASE_CYCLES = 64;

    typedef enum logic [1:0] {SEQ_IDLE, SEQ_LOAD, SEQ_RUN} seq_state_e;
endpackage : adc_mode_pkg

// >>> coef_correct.sv
// Offset and gain correction of one filter word
`timescale 1ns/10ps
module coef_correct
    import adc_mode_pkg::*;
#(
    parameter int WIDTH = 24
) (
    input wire logic [WIDTH-1:0] raw,
    input wire logic [WIDTH-1:0] offset,
    input wire logic [WIDTH-1:0] gain,
    output logic [WIDTH-1:0] corrected
);
    logic signed [WIDTH:0] diff;
    logic signed [2*WIDTH+1:0] prod;
    logic signed [2*WIDTH+1:0] scaled;
    logic signed [2*WIDTH+1:0] centred;

    always_comb begin
        // Offset first, then gain; gain normalised to unity at GAIN_UNITY
        diff = $signed({1'b0, raw}) - $signed({1'b0, offset}); // [RULE19]
        prod = diff * $signed({1'b0, gain}); // [RULE19]
        scaled = prod >>> GAIN_SHIFT; // [RULE18]
        centred = scaled + (2*WIDTH+2)'(1 << (WIDTH-1));
        // Saturate rather than wrap
        if (centred < 0) begin
            corrected = '0;
        end else if (centred > (2*WIDTH+2)'((1 << WIDTH) - 1)) begin
            corrected = '1;
        end else begin
            corrected = centred[WIDTH-1:0];
        end
    end
endmodule : coef_correct

// >>> adc_mode_ctrl.sv
// Mode, power-down and calibration control for a dual converter
// Summary of operation
// [RULE1] Mode code zero powers down the whole device.
// [RULE2] After reset the mode field is zero, device powered down.
// [RULE3] Each converter's own enable bit powers off only that converter.
// [RULE4] Power-down and disable keep every register, results included.
// [RULE5] Register access keeps working in power-down.
// [RULE6] Power-down or idle drives result-ready high.
// [RULE7] Calibration end or single conversion end switches to idle.
// [RULE8] Both enables clear with nonzero mode gives converter-disable mode.
// [RULE9] Converter-disable keeps PLL, current sources and switches alive.
// [RULE10] Factory gain coefficients load into gain registers at power-on.
// [RULE11] Four calibration modes: internal/system, zero/full scale.
// [RULE12] Calibration overwrites the factory coefficient.
// [RULE13] Each converter has its own offset and gain pair.
// [RULE14] Zero-scale stores to offset, full-scale stores to gain.
// [RULE15] Internal calibration switches an internal input to the modulator.
// [RULE16] Host applies system calibration voltage before starting it.
// [RULE17] Calibration always runs at the slowest update rate.
// [RULE18] Coefficients are normalised before use.
// [RULE19] Subtract offset first, then multiply by gain.
// [RULE20] Host detects calibration end through the ready flags.
// [RULE21] Host runs zero-scale before full-scale.
// [RULE22] Missing reference during calibration blocks update, sets error flag.
// [RULE23] Reset holds ready high, ignores access, restores defaults.
// [RULE24] Each nonzero mode code is distinct.
//
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
module adc_mode_ctrl
    import adc_mode_pkg::*;
#(
    parameter int WIDTH = 24,
    parameter logic [WIDTH-1:0] FACTORY_PRI_GAIN = GAIN_UNITY,
    parameter logic [WIDTH-1:0] FACTORY_SEC_GAIN = GAIN_UNITY
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [3:0] reg_addr,
    input wire logic [WIDTH-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [WIDTH-1:0] reg_rdata,
    input wire logic reference_missing_pin,
    input wire logic [WIDTH-1:0] pri_filter_word,
    input wire logic [WIDTH-1:0] sec_filter_word,
    output logic result_ready_n,
    output logic pri_power_on,
    output logic sec_power_on,
    output logic pll_on,
    output logic oscillator_keep_alive,
    output logic aux_functions_on,
    output logic internal_cal_input,
    output logic cal_full_scale,
    output logic [3:0] pri_rate,
    output logic [3:0] sec_rate
);
    // ************************************************************
    // State
    // ************************************************************
    logic [4:0] mode_reg, next_mode_reg;
    logic [3:0] pri_ctrl, next_pri_ctrl;
    logic [3:0] sec_ctrl, next_sec_ctrl;
    logic [WIDTH-1:0] coef_off [2];
    logic [WIDTH-1:0] coef_gain [2];
    logic [WIDTH-1:0] next_coef_off [2];
    logic [WIDTH-1:0] next_coef_gain [2];
    logic [WIDTH-1:0] data_reg [2];
    logic [WIDTH-1:0] next_data_reg [2];
    logic [1:0] converter_ready_flags, next_converter_ready_flags;
    logic primary_error_flag, next_primary_error_flag;
    logic ref_err_latch, next_ref_err_latch;
    seq_state_e seq, next_seq;
    logic [11:0] conv_cnt, next_conv_cnt;
    logic rdy_n, next_rdy_n;
    logic [WIDTH-1:0] rdata, next_rdata;
    logic ref_meta, reference_missing_flag;

    logic [2:0] mode_select_field;
    logic primary_converter_enable, secondary_converter_enable;
    logic cal_sel, is_cal, is_conv, conv_done, cal_active;
    logic [3:0] eff_rate [2];
    logic [WIDTH-1:0] corr [2];
    logic [11:0] conv_len;

    assign mode_select_field = mode_reg[MODE_LSB +: 3];
    assign cal_sel = mode_reg[MODE_SEL_BIT];
    assign primary_converter_enable = pri_ctrl[ENABLE_BIT];
    assign secondary_converter_enable = sec_ctrl[ENABLE_BIT];

    function automatic logic mode_is_cal(input logic [2:0] md);
        mode_is_cal = md[2]; // [RULE11] [RULE24]
    endfunction : mode_is_cal

    function automatic logic [11:0] period_of(input logic [3:0] rate);
        period_of = 12'(CONV_BASE_CYCLES) * (12'(rate) + 12'h001);
    endfunction : period_of

    assign is_cal = mode_is_cal(mode_select_field);
    assign is_conv = (mode_select_field == MD_CONTINUOUS) || (mode_select_field == MD_SINGLE);
    assign cal_active = is_cal && (seq == SEQ_RUN);

    // ************************************************************
    // Reference detect synchroniser
    // ************************************************************
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            ref_meta <= 1'b0;
            reference_missing_flag <= 1'b0;
        end else begin
            ref_meta <= reference_missing_pin;
            reference_missing_flag <= ref_meta;
        end
    end

    // ************************************************************
    // Correction path
    // ************************************************************
    generate
        for (genvar i = 0; i < 2; i++) begin : g_corr
            logic [WIDTH-1:0] raw_word;
            assign raw_word = (i == 0) ? pri_filter_word : sec_filter_word;
            assign eff_rate[i] = is_cal ? RATE_SLOWEST
                : {1'b0, ((i == 0) ? pri_ctrl[RATE_LSB +: 3] : sec_ctrl[RATE_LSB +: 3])}; // [RULE17]
            coef_correct #(
                .WIDTH(WIDTH)
            ) u_corr (
                .raw(raw_word),
                .offset(coef_off[i]),
                .gain(coef_gain[i]),
                .corrected(corr[i])
            );
        end
    endgenerate

    assign conv_len = period_of(cal_sel ? eff_rate[1] : eff_rate[0]);
    assign conv_done = (seq == SEQ_RUN) && (conv_cnt == 12'h000);

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        next_mode_reg = mode_reg;
        next_pri_ctrl = pri_ctrl;
        next_sec_ctrl = sec_ctrl;
        next_coef_off = coef_off;
        next_coef_gain = coef_gain;
        next_data_reg = data_reg;
        next_converter_ready_flags = converter_ready_flags;
        next_primary_error_flag = primary_error_flag;
        next_ref_err_latch = ref_err_latch;
        next_seq = seq;
        next_conv_cnt = conv_cnt;
        next_rdy_n = rdy_n;
        next_rdata = rdata;

        // Sequencer: power-down and disable send it back to SEQ_IDLE, where the count reloads
        case (seq)
            SEQ_IDLE: begin
                next_conv_cnt = conv_len;
            end
            SEQ_LOAD: begin
                next_conv_cnt = conv_len;
                next_ref_err_latch = 1'b0;
                next_seq = SEQ_RUN;
            end
            SEQ_RUN: begin
                if (is_cal && reference_missing_flag) begin
                    next_ref_err_latch = 1'b1;
                end
                if (conv_cnt != 12'h000) begin
                    next_conv_cnt = conv_cnt - 12'h001;
                end else begin
                    next_conv_cnt = conv_len;
                    if (is_cal) begin
                        if (ref_err_latch || reference_missing_flag) begin
                            next_primary_error_flag = 1'b1; // [RULE22]
                        end else if (mode_select_field[0] == 1'b0) begin
                            next_coef_off[cal_sel] = cal_sel ? sec_filter_word : pri_filter_word; // [RULE14]
                        end else begin
                            next_coef_gain[cal_sel] = cal_sel ? sec_filter_word : pri_filter_word; // [RULE12] [RULE13]
                        end
                        next_converter_ready_flags[cal_sel] = 1'b1; // [RULE20]
                        next_mode_reg[MODE_LSB +: 3] = MD_IDLE; // [RULE7]
                        next_seq = SEQ_IDLE;
                    end else begin
                        if (primary_converter_enable) begin
                            next_data_reg[0] = reference_missing_flag ? '1 : corr[0];
                            next_converter_ready_flags[0] = 1'b1;
                        end
                        if (secondary_converter_enable) begin
                            next_data_reg[1] = corr[1];
                            next_converter_ready_flags[1] = 1'b1;
                        end
                        next_rdy_n = 1'b0;
                        if (mode_select_field == MD_SINGLE) begin
                            next_mode_reg[MODE_LSB +: 3] = MD_IDLE; // [RULE7]
                            next_seq = SEQ_IDLE;
                        end
                    end
                end
            end
            default: next_seq = SEQ_IDLE;
        endcase

        // Leaving conversion or calibration stops the sequencer
        if (!(is_cal || is_conv) || (!primary_converter_enable && !secondary_converter_enable)) begin
            next_seq = SEQ_IDLE; // [RULE8]
        end
        if (mode_select_field == MD_POWER_DOWN || mode_select_field == MD_IDLE) begin
            next_rdy_n = 1'b1; // [RULE6]
        end

        // Register port works in every mode
        if (reg_rd) begin // [RULE5]
            case (reg_addr)
                OFS_MODE: next_rdata = WIDTH'(mode_reg);
                OFS_PRI_CTRL: next_rdata = WIDTH'(pri_ctrl);
                OFS_SEC_CTRL: next_rdata = WIDTH'(sec_ctrl);
                OFS_STATUS: next_rdata = WIDTH'({reference_missing_flag, primary_error_flag, converter_ready_flags});
                OFS_PRI_OFFSET: next_rdata = coef_off[0];
                OFS_PRI_GAIN: next_rdata = coef_gain[0];
                OFS_SEC_OFFSET: next_rdata = coef_off[1];
                OFS_SEC_GAIN: next_rdata = coef_gain[1];
                OFS_PRI_DATA: next_rdata = data_reg[0];
                OFS_SEC_DATA: next_rdata = data_reg[1];
                default: next_rdata = '0;
            endcase
            // Reading a result clears its ready flag; a set in the same cycle wins
            if (reg_addr == OFS_PRI_DATA && !conv_done) begin
                next_converter_ready_flags[0] = 1'b0;
                next_rdy_n = 1'b1;
            end
            if (reg_addr == OFS_SEC_DATA && !conv_done) begin
                next_converter_ready_flags[1] = 1'b0;
            end
        end else begin
            next_rdata = '0;
        end

        if (reg_wr) begin
            case (reg_addr)
                OFS_MODE: begin
                    next_mode_reg = reg_wdata[4:0]; // [RULE1]
                    next_seq = (mode_is_cal(reg_wdata[2:0]) || reg_wdata[2:1] == 2'b01) ? SEQ_LOAD : SEQ_IDLE;
                    if (mode_is_cal(reg_wdata[2:0])) begin
                        next_converter_ready_flags[reg_wdata[MODE_SEL_BIT]] = 1'b0;
                    end
                end
                OFS_PRI_CTRL: next_pri_ctrl = reg_wdata[3:0]; // [RULE3]
                OFS_SEC_CTRL: next_sec_ctrl = reg_wdata[3:0]; // [RULE3]
                OFS_STATUS: if (!(conv_done && is_cal)) next_primary_error_flag = 1'b0;
                OFS_PRI_OFFSET: next_coef_off[0] = reg_wdata;
                OFS_PRI_GAIN: next_coef_gain[0] = reg_wdata;
                OFS_SEC_OFFSET: next_coef_off[1] = reg_wdata;
                OFS_SEC_GAIN: next_coef_gain[1] = reg_wdata;
                default: ;
            endcase
        end
    end

    // ************************************************************
    // Registers; reset restores defaults and factory gains
    // ************************************************************
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin // [RULE23]
            mode_reg <= MODE_RESET; // [RULE2]
            pri_ctrl <= CTRL_RESET;
            sec_ctrl <= CTRL_RESET;
            coef_off[0] <= OFFSET_RESET;
            coef_off[1] <= OFFSET_RESET;
            coef_gain[0] <= FACTORY_PRI_GAIN; // [RULE10]
            coef_gain[1] <= FACTORY_SEC_GAIN; // [RULE10]
            data_reg[0] <= '0;
            data_reg[1] <= '0;
            converter_ready_flags <= 2'h0;
            primary_error_flag <= 1'b0;
            ref_err_latch <= 1'b0;
            seq <= SEQ_IDLE;
            conv_cnt <= 12'h000;
            rdy_n <= 1'b1;
            rdata <= '0;
        end else begin
            mode_reg <= next_mode_reg;
            pri_ctrl <= next_pri_ctrl;
            sec_ctrl <= next_sec_ctrl;
            coef_off <= next_coef_off; // [RULE4]
            coef_gain <= next_coef_gain;
            data_reg <= next_data_reg; // [RULE4]
            converter_ready_flags <= next_converter_ready_flags;
            primary_error_flag <= next_primary_error_flag;
            ref_err_latch <= next_ref_err_latch;
            seq <= next_seq;
            conv_cnt <= next_conv_cnt;
            rdy_n <= next_rdy_n;
            rdata <= next_rdata;
        end
    end

    // ************************************************************
    // Power and analog steering
    // ************************************************************
    always_comb begin
        result_ready_n = rdy_n | (mode_select_field == MD_POWER_DOWN) | (mode_select_field == MD_IDLE); // [RULE6]
        pri_power_on = (mode_select_field != MD_POWER_DOWN) && primary_converter_enable; // [RULE1] [RULE3]
        sec_power_on = (mode_select_field != MD_POWER_DOWN) && secondary_converter_enable; // [RULE3]
        pll_on = (mode_select_field != MD_POWER_DOWN); // [RULE9]
        aux_functions_on = (mode_select_field != MD_POWER_DOWN); // [RULE9]
        oscillator_keep_alive = mode_reg[MODE_KEEP_BIT];
        internal_cal_input = cal_active && !mode_select_field[1]; // [RULE15]
        cal_full_scale = is_cal && mode_select_field[0];
        pri_rate = eff_rate[0]; // [RULE17]
        sec_rate = eff_rate[1];
    end

    assign reg_rdata = rdata;
endmodule : adc_mode_ctrl

// >>> adc_mode_ctrl_assertions.sv
// Port checker for the mode and calibration controller
`timescale 1ns/10ps
module adc_mode_ctrl_assertions
    import adc_mode_pkg::*;
#(
    parameter int WIDTH = 24
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic [3:0] reg_addr,
    input wire logic [WIDTH-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [WIDTH-1:0] reg_rdata,
    input wire logic result_ready_n,
    input wire logic pri_power_on,
    input wire logic sec_power_on,
    input wire logic pll_on,
    input wire logic oscillator_keep_alive,
    input wire logic internal_cal_input,
    input wire logic cal_full_scale,
    input wire logic [3:0] pri_rate,
    input wire logic [3:0] sec_rate
);
    logic mode_wr;
    assign mode_wr = reg_wr && reg_addr == OFS_MODE;

    property p_pd;
        @(posedge clk_sys) disable iff (!nrst) mode_wr && reg_wdata[2:0] == MD_POWER_DOWN
            |=> !pll_on && !pri_power_on && !sec_power_on && result_ready_n;
    endproperty
    a_pd: assert property (p_pd) else $error("power-down outputs wrong");
    property p_idle;
        @(posedge clk_sys) disable iff (!nrst) mode_wr && reg_wdata[2:0] == MD_IDLE |=> result_ready_n && pll_on;
    endproperty
    a_idle: assert property (p_idle) else $error("idle left ready low");
    // No disable here: the reset itself is the cause
    property p_rst;
        @(posedge clk_sys) !nrst |=> result_ready_n && reg_rdata == '0 && !pri_power_on && pri_rate == 4'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    property p_rate;
        @(posedge clk_sys) disable iff (!nrst) internal_cal_input || cal_full_scale
            |-> pri_rate == RATE_SLOWEST && sec_rate == RATE_SLOWEST;
    endproperty
    a_rate: assert property (p_rate) else $error("calibration rate wrong");
    property p_cal_end;
        @(posedge clk_sys) disable iff (!nrst) $fell(internal_cal_input) |-> result_ready_n [*2];
    endproperty
    a_cal_end: assert property (p_cal_end) else $error("ready low after calibration");
    property p_keep;
        @(posedge clk_sys) disable iff (!nrst) mode_wr |=> oscillator_keep_alive == $past(reg_wdata[MODE_KEEP_BIT]);
    endproperty
    a_keep: assert property (p_keep) else $error("keep-alive not taken");
    property p_sec_only;
        @(posedge clk_sys) disable iff (!nrst) reg_wr && reg_addr == OFS_PRI_CTRL |=> $stable(sec_power_on);
    endproperty
    a_sec_only: assert property (p_sec_only) else $error("primary enable moved secondary");
    property p_pll;
        @(posedge clk_sys) disable iff (!nrst) mode_wr && reg_wdata[2:0] != MD_POWER_DOWN |=> pll_on;
    endproperty
    a_pll: assert property (p_pll) else $error("pll off in nonzero mode");
    property p_rdata;
        @(posedge clk_sys) disable iff (!nrst) !reg_rd || reg_addr > OFS_SEC_DATA |=> reg_rdata == '0;
    endproperty
    a_rdata: assert property (p_rdata) else $error("read data not zero");
endmodule : adc_mode_ctrl_assertions

bind adc_mode_ctrl adc_mode_ctrl_assertions #(.WIDTH(WIDTH)) u_adc_mode_ctrl_assertions (
    .clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .result_ready_n(result_ready_n), .pri_power_on(pri_power_on),
    .sec_power_on(sec_power_on), .pll_on(pll_on), .oscillator_keep_alive(oscillator_keep_alive),
    .internal_cal_input(internal_cal_input), .cal_full_scale(cal_full_scale), .pri_rate(pri_rate),
    .sec_rate(sec_rate));

// >>> front_end_model.sv
// Analogue front end model feeding both filter words
`timescale 1ns/10ps
module front_end_model (
    input wire logic internal_cal_input,
    input wire logic cal_full_scale,
    input wire logic [23:0] ext_word,
    output logic [23:0] pri_word,
    output logic [23:0] sec_word
);
    // Internal calibration ignores the pins entirely
    assign pri_word = internal_cal_input ? (cal_full_scale ? 24'hbff456 : 24'h800123) : ext_word;
    // Skewed so a swapped channel shows up
    assign sec_word = pri_word ^ 24'h0f0f0f;
endmodule : front_end_model

// >>> tb_top.sv
// Self-checking bench for the mode and calibration controller
`timescale 1ns/10ps
module tb_top
    import adc_mode_pkg::*;
;
    localparam logic [23:0] FPG = 24'h3f0001;
    localparam logic [23:0] FSG = 24'h401234;
    logic clk_sys, nrst, reg_wr, reg_rd, ref_missing, result_ready_n, pri_power_on, sec_power_on, pll_on;
    logic internal_cal_input, cal_full_scale, aux_on;
    logic [3:0] reg_addr, pri_rate, sec_rate;
    logic [23:0] reg_wdata, reg_rdata, ext_word, pri_word, sec_word, rv, d;
    logic [23:0] exp_reg [16];
    logic [15:0] seed;
    int fails, n_compared;

    adc_mode_ctrl #(.FACTORY_PRI_GAIN(FPG), .FACTORY_SEC_GAIN(FSG)) u_adc_mode_ctrl (
        .clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reference_missing_pin(ref_missing),
        .pri_filter_word(pri_word), .sec_filter_word(sec_word), .result_ready_n(result_ready_n),
        .pri_power_on(pri_power_on), .sec_power_on(sec_power_on), .pll_on(pll_on),
        .oscillator_keep_alive(), .aux_functions_on(aux_on), .internal_cal_input(internal_cal_input),
        .cal_full_scale(cal_full_scale), .pri_rate(pri_rate), .sec_rate(sec_rate));
    front_end_model u_front_end_model (.internal_cal_input(internal_cal_input),
        .cal_full_scale(cal_full_scale), .ext_word(ext_word), .pri_word(pri_word), .sec_word(sec_word));

    // ************************************************************
    // Bus and compare tasks
    // ************************************************************
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            fails++;
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [23:0] dat);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= dat;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
    endtask : rd
    task automatic rdc(input logic [3:0] a, input logic [23:0] exp);
        rd(a);
        chk(rv, exp);
    endtask : rdc
    // Bounded poll: the controller drops back to idle by itself
    task automatic wait_idle;
        rv = '1;
        for (int i = 0; i < 1500 && rv[2:0] != MD_IDLE; i++) rd(OFS_MODE);
        chk(24'(rv[2:0]), 24'(MD_IDLE));
    endtask : wait_idle
    task automatic cal(input logic s, input logic [2:0] c, input logic miss);
        logic [23:0] w;
        int k;
        ref_missing <= miss;
        repeat (3) @(posedge clk_sys);
        w = !c[1] ? (c[0] ? 24'hbff456 : 24'h800123) : ext_word;
        if (s) w = w ^ 24'h0f0f0f;
        k = 4 + 2 * s + c[0];
        wr(OFS_MODE, {20'h0, s, c});
        #1 chk(24'({pri_rate, sec_rate}), 24'hff);
        // Internal input is steered only once the load cycle has passed
        @(posedge clk_sys);
        #1 chk(24'({internal_cal_input, cal_full_scale}), 24'({!c[1], c[0]}));
        wait_idle();
        rd(OFS_STATUS);
        chk(24'({rv[ST_NOREF], rv[ST_PRIMARY_ERROR_FLAG]}), 24'({miss, miss}));
        if (!miss) chk(24'(rv[s]), 24'h1);
        if (!miss) exp_reg[k] = w;
        for (int j = 4; j < 8; j++) rdc(j[3:0], exp_reg[j]);
        rd(s ? OFS_SEC_DATA : OFS_PRI_DATA);
        wr(OFS_STATUS, 24'h0);
        ref_missing <= 1'b0;
    endtask : cal
    task automatic finish_test;
        if (fails == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : finish_test
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : lfsr
    // Offset first, then gain normalised at GAIN_SHIFT, recentred and saturated
    function automatic logic [23:0] corr_model(input logic [23:0] raw, off, gain);
        longint v;
        v = (((longint'(raw) - longint'(off)) * longint'(gain)) >>> GAIN_SHIFT) + 64'sh800000;
        if (v < 0) return 24'h0;
        if (v > 64'shffffff) return 24'hffffff;
        return v[23:0];
    endfunction : corr_model

    // ************************************************************
    // Clock, watchdog and sequence
    // ************************************************************
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (60000) @(posedge clk_sys);
        fails++;
        finish_test();
    end
    initial begin
        {nrst, reg_wr, reg_rd, ref_missing, reg_addr, reg_wdata} = '0;
        fails = 0;
        n_compared = 0;
        seed = 16'd30308;
        ext_word = 24'h0;
        exp_reg = '{4: OFFSET_RESET, 5: FPG, 6: OFFSET_RESET, 7: FSG, default: 24'h0};
        repeat (8) @(posedge clk_sys);
        nrst <= 1'b1;
        rdc(OFS_MODE, 24'h0);
        for (int j = 4; j < 8; j++) rdc(j[3:0], exp_reg[j]);
        rdc(4'hc, 24'h0);
        chk(24'({aux_on, pll_on, pri_power_on, sec_power_on, result_ready_n}), 24'h1);
        wr(OFS_PRI_CTRL, 24'h7);
        wr(OFS_SEC_CTRL, 24'h1);
        rdc(OFS_PRI_CTRL, 24'h7);
        cal(1'b0, MD_INT_ZERO, 1'b0);
        cal(1'b0, MD_INT_FULL, 1'b0);
        seed = lfsr(seed);
        ext_word <= {seed, seed[7:0]};
        cal(1'b1, MD_SYS_ZERO, 1'b0);
        seed = lfsr(seed);
        ext_word <= {seed[7:0], seed};
        cal(1'b1, MD_SYS_FULL, 1'b0);
        cal(1'b0, MD_SYS_FULL, 1'b1);
        #1 chk(24'(pri_rate), 24'h3);
        wr(OFS_MODE, 24'h12);
        for (int i = 0; i < 400 && result_ready_n !== 1'b0; i++) @(posedge clk_sys) #1;
        chk(24'(result_ready_n), 24'h0);
        wr(OFS_MODE, {21'h0, MD_POWER_DOWN});
        #1 chk(24'(result_ready_n), 24'h1);
        rd(OFS_PRI_DATA);
        d = rv;
        chk(d, corr_model(ext_word, exp_reg[4], exp_reg[5]));
        repeat (300) @(posedge clk_sys);
        rdc(OFS_PRI_DATA, d);
        wr(OFS_MODE, {21'h0, MD_SINGLE});
        wait_idle();
        chk(24'(result_ready_n), 24'h1);
        rdc(OFS_PRI_DATA, corr_model(ext_word, exp_reg[4], exp_reg[5]));
        wr(OFS_MODE, {21'h0, MD_IDLE});
        wr(OFS_PRI_CTRL, 24'h6);
        wr(OFS_MODE, {21'h0, MD_CONTINUOUS});
        #1 chk(24'({pri_power_on, sec_power_on, pll_on}), 24'h3);
        wr(OFS_SEC_CTRL, 24'h0);
        #1 chk(24'({pri_power_on, sec_power_on, pll_on, aux_on}), 24'h3);
        @(posedge clk_sys);
        nrst <= 1'b0;
        wr(OFS_MODE, 24'h2);
        nrst <= 1'b1;
        rdc(OFS_MODE, 24'h0);
        rdc(OFS_PRI_GAIN, FPG);
        rdc(OFS_SEC_OFFSET, OFFSET_RESET);
        finish_test();
    end
endmodule : tb_top
